// file: hbsq_pkg.sv
package hbsq_pkg;

	// ==========================================================
	// bridge count and field widths
	localparam int unsigned BRIDGE_COUNT = 3;
	localparam int unsigned MODE_W = 2;
	localparam int unsigned CODE_W = 4;
	localparam int unsigned STEP_W = 6;
	localparam int unsigned TIME_W = 8;
	localparam int unsigned CNT_W = 10;

	// ==========================================================
	// mode codes
	localparam logic [1:0] MODE_OFF_PASSIVE = 2'h0;
	localparam logic [1:0] MODE_LOW_ON = 2'h1;
	localparam logic [1:0] MODE_HIGH_ON = 2'h2;
	localparam logic [1:0] MODE_OFF_ACTIVE = 2'h3;

	// ==========================================================
	// current steps
	localparam int unsigned STATIC_STEP_SHIFT = 2;
	localparam logic [5:0] HOLD_STEP_LOW = 6'h0f;
	localparam logic [5:0] HOLD_STEP_HIGH = 6'h14;
	// hard-off is the strongest sink, flagged separately from the step scale
	localparam logic [5:0] HARD_OFF_STEP = 6'h3f;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned FILTER_TIME_NS = 2000;
	localparam int unsigned FILTER_CYCLES_INT =
		(FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] FILTER_CYCLES = 10'(FILTER_CYCLES_INT);
	localparam int unsigned CSN_LATENCY_NS = 3000;
	localparam int unsigned CSN_LATENCY_CYCLES = CSN_LATENCY_NS / CLK_PERIOD_NS;

	// ==========================================================
	// reset values of the latched settings
	localparam logic [5:0] MODE_RESET = 6'h00;
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic [2:0] PWM_RESET = 3'h0;
	localparam logic [7:0] TIME_RESET = 8'h01;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		PH_PASSIVE,
		PH_GUARD,
		PH_CHARGE,
		PH_HOLD
	} hbsq_phase_t;

	typedef enum logic [2:0] {
		GD_PASSIVE,
		GD_CHG_STATIC,
		GD_DCHG_STATIC,
		GD_HARD_OFF,
		GD_HOLD_ON,
		GD_HOLD_OFF
	} hbsq_drive_t;

endpackage

// file: hbsq_csn_sync.sv
`timescale 1ns/1ns
module hbsq_csn_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// chip select pin, active low
	input wire logic csn_n_i,
	// one-cycle pulse on the synchronised rising edge
	output logic rise_o
);

	// ==========================================================
	// two-flop synchroniser, edge taken from the second stage on
	logic meta_r;
	logic sync_r;
	logic last_r;
	logic rise_r;
	logic rise_nxt;

	always_comb begin
		rise_nxt = sync_r & ~last_r;
	end

	// idle high so a reset release does not fake an edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			last_r <= 1'b1;
			rise_r <= 1'b0;
		end else begin
			meta_r <= csn_n_i;
			sync_r <= meta_r;
			last_r <= sync_r;
			rise_r <= rise_nxt;
		end
	end

	assign rise_o = rise_r;

endmodule

// file: hbsq_sequencer.sv
`timescale 1ns/1ns
module hbsq_sequencer
	import hbsq_pkg::*;
#(
	parameter int unsigned BRIDGES = BRIDGE_COUNT
) (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	// chip select pin, active low, asynchronous
	input wire logic CSN_N_I,
	// settings from the register file, same clock
	input wire logic CHARGE_PUMP_ENABLE_I,
	input wire logic [BRIDGES-1:0] BRIDGE_PWM_ENABLE_I,
	input wire logic [BRIDGES*MODE_W-1:0] BRIDGE_MODE_CODE_I,
	input wire logic [BRIDGES*CODE_W-1:0] STATIC_GATE_CURRENT_CODE_I,
	input wire logic GATE_HOLD_CURRENT_SELECT_I,
	input wire logic [TIME_W-1:0] GUARD_CYCLES_I,
	input wire logic [TIME_W-1:0] BLANK_CYCLES_I,
	// high-side gate drive
	output logic [BRIDGES-1:0] HS_SOURCE_O,
	output logic [BRIDGES-1:0] HS_SINK_O,
	output logic [BRIDGES-1:0] HS_HARD_OFF_O,
	output logic [BRIDGES*STEP_W-1:0] HS_STEP_O,
	// low-side gate drive
	output logic [BRIDGES-1:0] LS_SOURCE_O,
	output logic [BRIDGES-1:0] LS_SINK_O,
	output logic [BRIDGES-1:0] LS_HARD_OFF_O,
	output logic [BRIDGES*STEP_W-1:0] LS_STEP_O,
	// status
	output logic [BRIDGES-1:0] BRIDGE_BUSY_O
);

	// ==========================================================
	// chip select edge
	logic csn_rise;

	hbsq_csn_sync hbsq_csn_sync_inst (
		.clk_i(SYS_CLK_I),
		.rst_i(RESET_I),
		.csn_n_i(CSN_N_I),
		.rise_o(csn_rise)
	);

	// ==========================================================
	// settings latched on the edge, applied one cycle later
	logic charge_pump_enable_r;
	logic charge_pump_enable_nxt;
	logic [BRIDGES-1:0] pwm_r;
	logic [BRIDGES-1:0] pwm_nxt;
	logic [BRIDGES*MODE_W-1:0] mode_r;
	logic [BRIDGES*MODE_W-1:0] mode_nxt;
	logic [BRIDGES*CODE_W-1:0] code_r;
	logic [BRIDGES*CODE_W-1:0] code_nxt;
	logic hold_sel_r;
	logic hold_sel_nxt;
	logic [TIME_W-1:0] guard_r;
	logic [TIME_W-1:0] guard_nxt;
	logic [TIME_W-1:0] blank_r;
	logic [TIME_W-1:0] blank_nxt;
	logic apply_r;
	logic apply_nxt;

	always_comb begin
		charge_pump_enable_nxt = charge_pump_enable_r;
		pwm_nxt = pwm_r;
		mode_nxt = mode_r;
		code_nxt = code_r;
		hold_sel_nxt = hold_sel_r;
		guard_nxt = guard_r;
		blank_nxt = blank_r;
		// new settings only count once the edge is in this clock domain
		if (csn_rise) begin
			charge_pump_enable_nxt = CHARGE_PUMP_ENABLE_I;
			pwm_nxt = BRIDGE_PWM_ENABLE_I;
			mode_nxt = BRIDGE_MODE_CODE_I;
			code_nxt = STATIC_GATE_CURRENT_CODE_I;
			hold_sel_nxt = GATE_HOLD_CURRENT_SELECT_I;
			guard_nxt = GUARD_CYCLES_I;
			blank_nxt = BLANK_CYCLES_I;
		end
		apply_nxt = csn_rise;
	end

	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			charge_pump_enable_r <= 1'b0;
			pwm_r <= PWM_RESET;
			mode_r <= MODE_RESET;
			code_r <= CODE_RESET;
			hold_sel_r <= 1'b0;
			guard_r <= TIME_RESET;
			blank_r <= TIME_RESET;
			apply_r <= 1'b0;
		end else begin
			charge_pump_enable_r <= charge_pump_enable_nxt;
			pwm_r <= pwm_nxt;
			mode_r <= mode_nxt;
			code_r <= code_nxt;
			hold_sel_r <= hold_sel_nxt;
			guard_r <= guard_nxt;
			blank_r <= blank_nxt;
			apply_r <= apply_nxt;
		end
	end

	// ==========================================================
	// shared durations, a zero guard setting still lasts one cycle
	logic [CNT_W-1:0] guard_len;
	logic [CNT_W-1:0] charge_len;
	logic [STEP_W-1:0] hold_step;

	always_comb begin
		guard_len = (guard_r == '0) ? CNT_W'(1) : CNT_W'(guard_r);
		charge_len = CNT_W'(blank_r) + FILTER_CYCLES;
		hold_step = hold_sel_r ? HOLD_STEP_HIGH : HOLD_STEP_LOW;
	end

	// ==========================================================
	// drive kind of one gate for a phase and target mode
	function automatic hbsq_drive_t gate_drive(input hbsq_phase_t ph,
			input logic [1:0] tgt, input logic high_side);
		logic own_on;
		own_on = high_side ? (tgt == MODE_HIGH_ON) : (tgt == MODE_LOW_ON);
		gate_drive = GD_PASSIVE;
		case (ph)
			PH_PASSIVE: begin
				gate_drive = GD_PASSIVE;
			end
			PH_GUARD: begin
				gate_drive = GD_DCHG_STATIC;
			end
			PH_CHARGE: begin
				gate_drive = own_on ? GD_CHG_STATIC : GD_HARD_OFF;
			end
			PH_HOLD: begin
				gate_drive = own_on ? GD_HOLD_ON : GD_HOLD_OFF;
			end
			default: begin
				gate_drive = GD_PASSIVE;
			end
		endcase
	endfunction

	// ==========================================================
	// one sequencer per bridge
	genvar gi;
	generate
		for (gi = 0; gi < BRIDGES; gi++) begin : g_bridge
			hbsq_phase_t phase_r;
			hbsq_phase_t phase_nxt;
			logic [1:0] cur_r;
			logic [1:0] cur_nxt;
			logic [CNT_W-1:0] cnt_r;
			logic [CNT_W-1:0] cnt_nxt;
			logic [1:0] new_mode;
			logic static_ok;
			logic swap;
			logic [STEP_W-1:0] static_step;
			hbsq_drive_t hs_drv;
			hbsq_drive_t ls_drv;
			logic hs_src_nxt;
			logic hs_snk_nxt;
			logic hs_hard_nxt;
			logic [STEP_W-1:0] hs_step_nxt;
			logic ls_src_nxt;
			logic ls_snk_nxt;
			logic ls_hard_nxt;
			logic [STEP_W-1:0] ls_step_nxt;
			logic hs_src_r;
			logic hs_snk_r;
			logic hs_hard_r;
			logic [STEP_W-1:0] hs_step_r;
			logic ls_src_r;
			logic ls_snk_r;
			logic ls_hard_r;
			logic [STEP_W-1:0] ls_step_r;
			logic busy_r;
			logic busy_nxt;

			always_comb begin
				static_ok = charge_pump_enable_r & ~pwm_r[gi];
				new_mode = mode_r[gi*MODE_W +: MODE_W];
				swap = ((cur_r == MODE_LOW_ON) && (new_mode == MODE_HIGH_ON)) ||
					((cur_r == MODE_HIGH_ON) && (new_mode == MODE_LOW_ON));
				phase_nxt = phase_r;
				cur_nxt = cur_r;
				cnt_nxt = cnt_r;
				if (apply_r && !static_ok) begin
					// pump off or pwm owns the bridge: drop to passive at once
					phase_nxt = PH_PASSIVE;
					cur_nxt = MODE_OFF_PASSIVE;
				end else if (apply_r && (new_mode != cur_r)) begin
					cur_nxt = new_mode;
					if ((new_mode == MODE_OFF_PASSIVE) ||
							(new_mode == MODE_OFF_ACTIVE) || swap) begin
						phase_nxt = PH_GUARD;
						cnt_nxt = guard_len - CNT_W'(1);
					end else begin
						// from off, no conducting partner to protect against
						phase_nxt = PH_CHARGE;
						cnt_nxt = charge_len - CNT_W'(1);
					end
				end else if (cnt_r != '0) begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end else begin
					case (phase_r)
						PH_GUARD: begin
							if (cur_r == MODE_OFF_PASSIVE) begin
								phase_nxt = PH_PASSIVE;
							end else if (cur_r == MODE_OFF_ACTIVE) begin
								phase_nxt = PH_HOLD;
							end else begin
								phase_nxt = PH_CHARGE;
								cnt_nxt = charge_len - CNT_W'(1);
							end
						end
						PH_CHARGE: begin
							phase_nxt = PH_HOLD;
						end
						PH_PASSIVE, PH_HOLD: begin
							phase_nxt = phase_r;
						end
						default: begin
							phase_nxt = PH_PASSIVE;
						end
					endcase
				end
			end

			always_comb begin
				static_step = STEP_W'(code_r[gi*CODE_W +: CODE_W]) << STATIC_STEP_SHIFT;
				hs_drv = gate_drive(phase_nxt, cur_nxt, 1'b1);
				ls_drv = gate_drive(phase_nxt, cur_nxt, 1'b0);
				hs_src_nxt = (hs_drv == GD_CHG_STATIC) || (hs_drv == GD_HOLD_ON);
				hs_snk_nxt = (hs_drv == GD_DCHG_STATIC) || (hs_drv == GD_HOLD_OFF) ||
					(hs_drv == GD_HARD_OFF);
				hs_hard_nxt = (hs_drv == GD_HARD_OFF);
				ls_src_nxt = (ls_drv == GD_CHG_STATIC) || (ls_drv == GD_HOLD_ON);
				ls_snk_nxt = (ls_drv == GD_DCHG_STATIC) || (ls_drv == GD_HOLD_OFF) ||
					(ls_drv == GD_HARD_OFF);
				ls_hard_nxt = (ls_drv == GD_HARD_OFF);
				case (hs_drv)
					GD_CHG_STATIC, GD_DCHG_STATIC: hs_step_nxt = static_step;
					GD_HOLD_ON, GD_HOLD_OFF: hs_step_nxt = hold_step;
					GD_HARD_OFF: hs_step_nxt = HARD_OFF_STEP;
					default: hs_step_nxt = '0;
				endcase
				case (ls_drv)
					GD_CHG_STATIC, GD_DCHG_STATIC: ls_step_nxt = static_step;
					GD_HOLD_ON, GD_HOLD_OFF: ls_step_nxt = hold_step;
					GD_HARD_OFF: ls_step_nxt = HARD_OFF_STEP;
					default: ls_step_nxt = '0;
				endcase
				busy_nxt = (phase_nxt == PH_GUARD) || (phase_nxt == PH_CHARGE);
			end

			always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					phase_r <= PH_PASSIVE;
					cur_r <= MODE_OFF_PASSIVE;
					cnt_r <= '0;
					hs_src_r <= 1'b0;
					hs_snk_r <= 1'b0;
					hs_hard_r <= 1'b0;
					hs_step_r <= '0;
					ls_src_r <= 1'b0;
					ls_snk_r <= 1'b0;
					ls_hard_r <= 1'b0;
					ls_step_r <= '0;
					busy_r <= 1'b0;
				end else begin
					phase_r <= phase_nxt;
					cur_r <= cur_nxt;
					cnt_r <= cnt_nxt;
					hs_src_r <= hs_src_nxt;
					hs_snk_r <= hs_snk_nxt;
					hs_hard_r <= hs_hard_nxt;
					hs_step_r <= hs_step_nxt;
					ls_src_r <= ls_src_nxt;
					ls_snk_r <= ls_snk_nxt;
					ls_hard_r <= ls_hard_nxt;
					ls_step_r <= ls_step_nxt;
					busy_r <= busy_nxt;
				end
			end

			assign HS_SOURCE_O[gi] = hs_src_r;
			assign HS_SINK_O[gi] = hs_snk_r;
			assign HS_HARD_OFF_O[gi] = hs_hard_r;
			assign HS_STEP_O[gi*STEP_W +: STEP_W] = hs_step_r;
			assign LS_SOURCE_O[gi] = ls_src_r;
			assign LS_SINK_O[gi] = ls_snk_r;
			assign LS_HARD_OFF_O[gi] = ls_hard_r;
			assign LS_STEP_O[gi*STEP_W +: STEP_W] = ls_step_r;
			assign BRIDGE_BUSY_O[gi] = busy_r;
		end
	endgenerate

endmodule

// file: hbsq_seq_props.sv
`timescale 1ns/1ns
module hbsq_seq_props
	import hbsq_pkg::*;
#(
	parameter int unsigned BRIDGES = BRIDGE_COUNT
) (
	// clock, reset, chip select
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic CSN_N_I,
	// settings
	input wire logic CHARGE_PUMP_ENABLE_I,
	input wire logic [BRIDGES-1:0] BRIDGE_PWM_ENABLE_I,
	input wire logic [BRIDGES*MODE_W-1:0] BRIDGE_MODE_CODE_I,
	input wire logic [BRIDGES*CODE_W-1:0] STATIC_GATE_CURRENT_CODE_I,
	input wire logic GATE_HOLD_CURRENT_SELECT_I,
	input wire logic [TIME_W-1:0] GUARD_CYCLES_I,
	input wire logic [TIME_W-1:0] BLANK_CYCLES_I,
	// gate drive and status
	input wire logic [BRIDGES-1:0] HS_SOURCE_O,
	input wire logic [BRIDGES-1:0] HS_SINK_O,
	input wire logic [BRIDGES-1:0] HS_HARD_OFF_O,
	input wire logic [BRIDGES*STEP_W-1:0] HS_STEP_O,
	input wire logic [BRIDGES-1:0] LS_SOURCE_O,
	input wire logic [BRIDGES-1:0] LS_SINK_O,
	input wire logic [BRIDGES-1:0] LS_HARD_OFF_O,
	input wire logic [BRIDGES*STEP_W-1:0] LS_STEP_O,
	input wire logic [BRIDGES-1:0] BRIDGE_BUSY_O
);
	// ==========================================================
	// phase length counters, bridge 0 only
	logic [9:0] hard_cnt_r;
	logic [9:0] guard_cnt_r;
	logic guard0;
	logic hard0;
	// settings as the device latched them, taken in step with its outputs;
	// the raw inputs move ahead of the commit edge and would mislead
	logic [4:0] csn_d_r;
	logic hold_ref_r;
	logic [CODE_W-1:0] code_ref_r;
	logic [TIME_W-1:0] guard_ref_r;
	logic [TIME_W-1:0] blank_ref_r;
	logic [9:0] guard_exp;
	assign hard0 = HS_HARD_OFF_O[0] | LS_HARD_OFF_O[0];
	assign guard0 = BRIDGE_BUSY_O[0] & HS_SINK_O[0] & LS_SINK_O[0] & ~hard0;
	assign guard_exp = (guard_ref_r == '0) ? 10'h001 : 10'(guard_ref_r);
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			hard_cnt_r <= 10'h000;
			guard_cnt_r <= 10'h000;
			csn_d_r <= 5'h1f;
			hold_ref_r <= 1'b0;
			code_ref_r <= '0;
			guard_ref_r <= TIME_RESET;
			blank_ref_r <= TIME_RESET;
		end else begin
			hard_cnt_r <= hard0 ? hard_cnt_r + 10'h001 : 10'h000;
			guard_cnt_r <= guard0 ? guard_cnt_r + 10'h001 : 10'h000;
			csn_d_r <= {csn_d_r[3:0], CSN_N_I};
			if (csn_d_r[3] && !csn_d_r[4]) begin
				hold_ref_r <= GATE_HOLD_CURRENT_SELECT_I;
				code_ref_r <= STATIC_GATE_CURRENT_CODE_I[CODE_W-1:0];
				guard_ref_r <= GUARD_CYCLES_I;
				blank_ref_r <= BLANK_CYCLES_I;
			end
		end
	end

	// ==========================================================
	// properties
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);

	pump_off_a: assert property ($rose(CSN_N_I) && !CHARGE_PUMP_ENABLE_I |-> ##[1:30]
		(HS_SOURCE_O | HS_SINK_O | LS_SOURCE_O | LS_SINK_O) == '0) else $error("pump off drive");
	pwm_off_a: assert property ($rose(CSN_N_I) && BRIDGE_PWM_ENABLE_I[0] |-> ##[1:30]
		!(HS_SOURCE_O[0] | HS_SINK_O[0] | LS_SOURCE_O[0] | LS_SINK_O[0])) else $error("pwm drive");
	high_on_a: assert property ($rose(CSN_N_I) && CHARGE_PUMP_ENABLE_I
		&& !BRIDGE_PWM_ENABLE_I[0] && BRIDGE_MODE_CODE_I[1:0] == MODE_HIGH_ON
		|-> ##[1:60] HS_SOURCE_O[0] && LS_SINK_O[0]) else $error("high side not on");
	hard_hs_a: assert property (HS_HARD_OFF_O[0] |-> HS_SINK_O[0] && LS_SOURCE_O[0]
		&& HS_STEP_O[5:0] == HARD_OFF_STEP) else $error("high hard off");
	hard_ls_a: assert property (LS_HARD_OFF_O[0] |-> LS_SINK_O[0] && HS_SOURCE_O[0]
		&& LS_STEP_O[5:0] == HARD_OFF_STEP) else $error("low hard off");
	no_shoot_a: assert property ((HS_SOURCE_O & LS_SOURCE_O) == '0
		&& (HS_SOURCE_O & HS_SINK_O) == '0) else $error("cross conduction");
	guard_step_a: assert property (guard0 |-> HS_STEP_O[5:0] == {code_ref_r, 2'h0}
		&& LS_STEP_O[5:0] == HS_STEP_O[5:0]) else $error("static step");
	hold_step_a: assert property (HS_SOURCE_O[0] && !BRIDGE_BUSY_O[0] |->
		HS_STEP_O[5:0] == (hold_ref_r ? HOLD_STEP_HIGH : HOLD_STEP_LOW)) else $error("hold step");
	charge_len_a: assert property ($fell(hard0) |->
		hard_cnt_r == 10'(blank_ref_r) + FILTER_CYCLES) else $error("charge length");
	guard_len_a: assert property ($fell(guard0) |-> guard_cnt_r == guard_exp)
		else $error("guard length");
endmodule

bind hbsq_sequencer hbsq_seq_props #(.BRIDGES(BRIDGES)) hbsq_seq_props_inst (
	.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .CSN_N_I(CSN_N_I),
	.CHARGE_PUMP_ENABLE_I(CHARGE_PUMP_ENABLE_I), .BRIDGE_PWM_ENABLE_I(BRIDGE_PWM_ENABLE_I),
	.BRIDGE_MODE_CODE_I(BRIDGE_MODE_CODE_I), .STATIC_GATE_CURRENT_CODE_I(STATIC_GATE_CURRENT_CODE_I),
	.GATE_HOLD_CURRENT_SELECT_I(GATE_HOLD_CURRENT_SELECT_I), .GUARD_CYCLES_I(GUARD_CYCLES_I),
	.BLANK_CYCLES_I(BLANK_CYCLES_I), .HS_SOURCE_O(HS_SOURCE_O), .HS_SINK_O(HS_SINK_O),
	.HS_HARD_OFF_O(HS_HARD_OFF_O), .HS_STEP_O(HS_STEP_O), .LS_SOURCE_O(LS_SOURCE_O),
	.LS_SINK_O(LS_SINK_O), .LS_HARD_OFF_O(LS_HARD_OFF_O), .LS_STEP_O(LS_STEP_O),
	.BRIDGE_BUSY_O(BRIDGE_BUSY_O));

// file: hbsq_host_model.sv
`timescale 1ns/1ns
module hbsq_host_model (
	// clock
	input wire logic clk_i,
	// command pins and settings
	output logic csn_n_o,
	output logic pump_o,
	output logic [2:0] pwm_o,
	output logic [5:0] mode_o,
	output logic [11:0] code_o,
	output logic hold_o
);
	initial begin
		csn_n_o = 1'b1;
		pump_o = 1'b0;
		pwm_o = 3'h0;
		mode_o = 6'h00;
		code_o = 12'h000;
		hold_o = 1'b0;
	end

	// same mode and code on all three bridges
	task automatic send(input logic pe, input logic [2:0] pw, input logic [1:0] m,
		input logic [3:0] c, input logic h);
		@(posedge clk_i);
		#1;
		pump_o = pe;
		pwm_o = pw;
		mode_o = {3{m}};
		code_o = {3{c}};
		hold_o = h;
		csn_n_o = 1'b0;
		repeat (4) @(posedge clk_i);
		#1;
		csn_n_o = 1'b1;
		// settings held while the device syncs the commit edge
		repeat (4) @(posedge clk_i);
		#1;
	endtask
endmodule

// file: half_bridge_static_gate_sequencer_tb.sv
`timescale 1ns/1ns
module half_bridge_static_gate_sequencer_tb;
	import hbsq_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic csn_n, pump, hold;
	logic [2:0] pwm, hs_src, hs_snk, hs_hard, ls_src, ls_snk, ls_hard, busy;
	logic [5:0] mode;
	logic [11:0] code;
	logic [17:0] hs_step, ls_step;
	logic [7:0] guard = 8'h03;
	logic [7:0] blank = 8'h05;
	int n_fail = 0;
	int n_compared = 0;

	always #50 clk = ~clk;

	hbsq_host_model hbsq_host_model_inst (.clk_i(clk), .csn_n_o(csn_n), .pump_o(pump),
		.pwm_o(pwm), .mode_o(mode), .code_o(code), .hold_o(hold));

	hbsq_sequencer hbsq_sequencer_inst (.SYS_CLK_I(clk), .RESET_I(rst), .CSN_N_I(csn_n),
		.CHARGE_PUMP_ENABLE_I(pump), .BRIDGE_PWM_ENABLE_I(pwm), .BRIDGE_MODE_CODE_I(mode),
		.STATIC_GATE_CURRENT_CODE_I(code), .GATE_HOLD_CURRENT_SELECT_I(hold),
		.GUARD_CYCLES_I(guard), .BLANK_CYCLES_I(blank), .HS_SOURCE_O(hs_src),
		.HS_SINK_O(hs_snk), .HS_HARD_OFF_O(hs_hard), .HS_STEP_O(hs_step), .LS_SOURCE_O(ls_src),
		.LS_SINK_O(ls_snk), .LS_HARD_OFF_O(ls_hard), .LS_STEP_O(ls_step), .BRIDGE_BUSY_O(busy));

	// ==========================================================
	// helpers
	task automatic summarize();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// bound of 30 clocks doubles as the 3 us reaction limit
	task automatic wait_busy(input logic v);
		int i;
		for (i = 0; i < 30 && (|busy) !== v; i++) begin
			@(posedge clk);
			#1;
		end
		if ((|busy) !== v) begin
			n_fail++;
			summarize();
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic t_guard(input logic [1:0] m, input logic h);
		logic on;
		logic [5:0] hs;
		on = (m == MODE_HIGH_ON);
		hs = h ? HOLD_STEP_HIGH : HOLD_STEP_LOW;
		hbsq_host_model_inst.send(1'b1, 3'h0, m, 4'h9, h);
		wait_busy(1'b1);
		check("guard", {hs_snk, ls_snk, hs_src, ls_src}, 12'hfc0);
		check("guard step", hs_step, {3{6'h24}});
		repeat (3) @(posedge clk);
		#1;
		check("charge", {hs_src, hs_hard, ls_src, ls_hard}, on ? 12'he07 : 12'h1f8);
		check("hard step", on ? ls_step : hs_step, {3{HARD_OFF_STEP}});
		wait_busy(1'b0);
		check("hold", {hs_src, hs_snk, ls_src, ls_snk, hs_hard, ls_hard},
			on ? 18'o700700 : 18'o077000);
		check("hold step", {hs_step, ls_step}, {6{hs}});
	endtask

	task automatic t_skip();
		hbsq_host_model_inst.send(1'b1, 3'h0, MODE_OFF_ACTIVE, 4'h9, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		hbsq_host_model_inst.send(1'b1, 3'h0, MODE_HIGH_ON, 4'h9, 1'b1);
		wait_busy(1'b1);
		check("no guard", {hs_src, ls_hard}, 6'h3f);
		wait_busy(1'b0);
	endtask

	task automatic t_same();
		logic [2:0] seen;
		seen = 3'h0;
		hbsq_host_model_inst.send(1'b1, 3'h0, MODE_HIGH_ON, 4'h9, 1'b1);
		repeat (30) begin
			@(posedge clk);
			#1;
			seen = seen | busy;
		end
		check("restart", {seen, hs_src}, 6'h07);
	endtask

	// zero guard still lasts one cycle, zero blank leaves the filter time
	task automatic t_zero();
		int n;
		n = 0;
		guard = 8'h00;
		blank = 8'h00;
		hbsq_host_model_inst.send(1'b1, 3'h0, MODE_LOW_ON, 4'h9, 1'b1);
		wait_busy(1'b1);
		check("short guard", {hs_snk, ls_snk, hs_src, ls_src}, 12'hfc0);
		@(posedge clk);
		#1;
		check("short charge", {ls_src, hs_hard}, 6'h3f);
		while (busy !== 3'h0 && n < 30) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("charge cycles", n, FILTER_CYCLES_INT);
		guard = 8'h03;
		blank = 8'h05;
	endtask

	task automatic t_codes();
		logic [1:0] m;
		logic [5:0] hs;
		for (int i = 0; i < 16; i++) begin
			m = i[0] ? MODE_OFF_ACTIVE : MODE_OFF_PASSIVE;
			hs = i[1] ? HOLD_STEP_HIGH : HOLD_STEP_LOW;
			hbsq_host_model_inst.send(1'b1, 3'h0, m, i[3:0], i[1]);
			wait_busy(1'b1);
			check("off step", {hs_step, ls_step}, {6{i[3:0], 2'h0}});
			wait_busy(1'b0);
			check("off drive", {hs_src, hs_snk, ls_src, ls_snk}, i[0] ? 12'h1c7 : 12'h000);
			check("off hold", {hs_step, ls_step}, i[0] ? {6{hs}} : 36'h0);
		end
	endtask

	task automatic t_pwm();
		hbsq_host_model_inst.send(1'b1, 3'h1, MODE_HIGH_ON, 4'h9, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		check("pwm", {hs_src, hs_snk, ls_src, ls_snk}, 12'hc06);
	endtask

	task automatic t_pump();
		hbsq_host_model_inst.send(1'b0, 3'h0, MODE_HIGH_ON, 4'h9, 1'b1);
		repeat (30) @(posedge clk);
		#1;
		check("pump off", {hs_src, hs_snk, ls_src, ls_snk, busy}, 15'h0);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		check("reset", {hs_src, hs_snk, ls_src, ls_snk, busy}, 15'h0);
		hbsq_host_model_inst.send(1'b1, 3'h0, MODE_HIGH_ON, 4'h9, 1'b0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		t_guard(MODE_LOW_ON, 1'b0);
		t_guard(MODE_HIGH_ON, 1'b1);
		t_skip();
		t_same();
		t_zero();
		t_codes();
		t_pwm();
		t_pump();
		summarize();
	end
endmodule
